// [verilog/cmpl_top.v]
// Contract
// RQ1 - filter out comparator glitches under two cycles
// RQ2 - bypass filter in sleep or idle
// RQ3 - asynchronous wake path to interrupt controller
// RQ4 - stop-in-idle bit turns comparator off
// RQ5 - any stop-in-idle bit stops whole group; the code counts only the bits of enabled comparators
// RQ6 - one-cycle pulse triggers ADC and interrupt
// RQ7 - reference value register drives DAC code
// RQ8 - disabled module powers down DAC, comparator
// RQ9 - programmable output polarity before filtering
// RQ10 - ten-bit DAC code to inverting input
// RQ11 - one event drives interrupt, ADC, PWM
// RQ12 - synchronise comparator output, pulse per transition; the code pulses only on rising transitions of the polarity-adjusted level
`timescale 1ns/100ps
`include "cmpl_defines.vh"
module cmpl_top #(
  parameter NUM_CMP  = 4,
  parameter DAC_BITS = `CMPL_DAC_BITS
) (
  input  wire                         clk,
  input  wire                         srst,
  // apb slave
  input  wire                         psel,
  input  wire                         penable,
  input  wire                         pwrite,
  input  wire [7:0]                   paddr,
  input  wire [31:0]                  pwdata,
  output reg  [31:0]                  prdata,
  output reg                          pready,
  output reg                          pslverr,
  // power modes
  input  wire                         idle_mode,
  input  wire                         sleep_mode,
  // analog side
  input  wire [NUM_CMP-1:0]           cmp_raw,
  output reg  [NUM_CMP*DAC_BITS-1:0]  dac_code_q,
  output reg  [NUM_CMP-1:0]           dac_pwr_en_q,
  output reg  [NUM_CMP-1:0]           cmp_pwr_en_q,
  // event consumers
  output reg  [NUM_CMP-1:0]           adc_trig_q,
  output reg  [NUM_CMP-1:0]           pwm_limit_q,
  output wire [NUM_CMP-1:0]           wake_async,
  output reg                          irq_q
);
  // ==========================================================
  // register storage
  reg  [15:0]         ctrl_q [0:NUM_CMP-1];
  reg  [NUM_CMP-1:0]  stat_q;
  reg  [NUM_CMP-1:0]  mask_q;
  reg                 lowpwr_q;
  wire [NUM_CMP-1:0]  cmp_sync;
  wire [NUM_CMP-1:0]  lvl;
  wire [NUM_CMP-1:0]  pls;
  wire [NUM_CMP-1:0]  en_v;
  wire [NUM_CMP-1:0]  sidl_v;
  wire [NUM_CMP-1:0]  pol_v;
  wire                group_stop;
  wire                acc;
  wire                wr_done;
  reg  [NUM_CMP-1:0]  ctrl_sel;
  reg  [NUM_CMP-1:0]  dac_sel;
  wire                stat_sel;
  wire                mask_sel;
  wire                addr_hit;
  wire [NUM_CMP*16-1:0] ctrl_rd;
  reg  [31:0]         rd_word;
  wire [NUM_CMP-1:0]  stat_clr;
  wire [NUM_CMP-1:0]  stat_d;
  wire [NUM_CMP-1:0]  run_en;
  integer             i;
  integer             j;
  integer             k;
  integer             m;

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g = g + 1) begin : g_vec
      assign en_v[g]   = ctrl_q[g][`CMPL_CTRL_EN_BIT];
      assign sidl_v[g] = ctrl_q[g][`CMPL_CTRL_SIDL_BIT];
      assign pol_v[g]  = ctrl_q[g][`CMPL_CTRL_POL_BIT];
      // read view: bit 0 shows the filtered level, not the stored bit
      assign ctrl_rd[g*16 +: 16] = {ctrl_q[g][15:1], lvl[g]};
    end
  endgenerate

  // any enabled stop-in-idle bit idles the whole group
  assign group_stop = |(sidl_v & en_v) & idle_mode; // RQ4 RQ5

  // ==========================================================
  // comparator path
  cmpl_sync #(
    .WIDTH (NUM_CMP)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (cmp_raw),
    .sync_out (cmp_sync)
  ); // RQ12

  generate
    for (g = 0; g < NUM_CMP; g = g + 1) begin : g_chan
      cmpl_chan #(
        .FILT_CYCLES (`CMPL_FILT_CYCLES)
      ) u_chan (
        .clk      (clk),
        .srst     (srst),
        .cmp_sync (cmp_sync[g]),
        .polarity (pol_v[g]),
        .enable   (en_v[g] & ~group_stop),
        .bypass   (lowpwr_q),
        .level    (lvl[g]),
        .pulse    (pls[g])
      );
    end
  endgenerate

  // unclocked wake path, gated only by held mode and enable state
  assign wake_async = (cmp_raw ^ pol_v) & cmp_pwr_en_q & {NUM_CMP{lowpwr_q}}; // RQ3

  // ==========================================================
  // apb slave: one wait state, answer from flops
  assign acc     = psel & penable;
  assign wr_done = acc & pready & pwrite & ~pslverr;

  // ==========================================================
  // address decode, one select per register
  always @* begin
    ctrl_sel = {NUM_CMP{1'b0}};
    dac_sel  = {NUM_CMP{1'b0}};
    for (k = 0; k < NUM_CMP; k = k + 1) begin
      ctrl_sel[k] = (paddr == `CMPL_CTRL_BASE + k[7:0] * `CMPL_CHAN_STRIDE);
      dac_sel[k]  = (paddr == `CMPL_DACV_BASE + k[7:0] * `CMPL_CHAN_STRIDE);
    end
  end

  assign stat_sel = (paddr == `CMPL_STAT_OFS);
  assign mask_sel = (paddr == `CMPL_MASK_OFS);
  assign addr_hit = |{ctrl_sel, dac_sel, stat_sel, mask_sel};

  // read word of the selected register, zero when unmapped
  always @* begin
    rd_word = 32'h0000_0000;
    for (m = 0; m < NUM_CMP; m = m + 1) begin
      if (ctrl_sel[m]) begin
        rd_word = {16'h0000, ctrl_rd[m*16 +: 16]};
      end
      if (dac_sel[m]) begin
        rd_word = {{(32-DAC_BITS){1'b0}}, dac_code_q[m*DAC_BITS +: DAC_BITS]};
      end
    end
    if (stat_sel) begin
      rd_word = {{(32-NUM_CMP){1'b0}}, stat_q};
    end
    if (mask_sel) begin
      rd_word = {{(32-NUM_CMP){1'b0}}, mask_q};
    end
  end

  // answer one cycle into the access phase, then drop
  always @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~addr_hit;
      prdata  <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // control and mask registers
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < NUM_CMP; i = i + 1) begin
        ctrl_q[i] <= `CMPL_CTRL_RST;
      end
      mask_q <= {NUM_CMP{1'b0}};
    end else if (wr_done) begin
      for (i = 0; i < NUM_CMP; i = i + 1) begin
        if (ctrl_sel[i]) begin
          ctrl_q[i] <= pwdata[15:0] & `CMPL_CTRL_WMASK;
        end
      end
      if (mask_sel) begin
        mask_q <= pwdata[NUM_CMP-1:0];
      end
    end
  end

  // ==========================================================
  // reference values, straight onto the dac code lines
  always @(posedge clk) begin
    if (srst) begin
      for (j = 0; j < NUM_CMP; j = j + 1) begin
        dac_code_q[j*DAC_BITS +: DAC_BITS] <= `CMPL_DAC_RST;
      end
    end else if (wr_done) begin
      for (j = 0; j < NUM_CMP; j = j + 1) begin
        if (dac_sel[j]) begin
          dac_code_q[j*DAC_BITS +: DAC_BITS] <= pwdata[DAC_BITS-1:0]; // RQ7 RQ10
        end
      end
    end
  end

  // ==========================================================
  // sticky event status: set wins over write-one-to-clear
  assign stat_clr = (wr_done && stat_sel) ? pwdata[NUM_CMP-1:0] : {NUM_CMP{1'b0}};
  assign stat_d   = (stat_q & ~stat_clr) | pls; // RQ6 RQ11

  always @(posedge clk) begin
    if (srst) begin
      stat_q <= {NUM_CMP{1'b0}};
    end else begin
      stat_q <= stat_d;
    end
  end

  // ==========================================================
  // level interrupt, follows status so a clear drops it at once
  always @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q); // RQ6
    end
  end

  // ==========================================================
  // low-power mode and analog power enables
  assign run_en = en_v & {NUM_CMP{~group_stop}};

  always @(posedge clk) begin
    if (srst) begin
      lowpwr_q     <= 1'b0;
      cmp_pwr_en_q <= {NUM_CMP{1'b0}};
      dac_pwr_en_q <= {NUM_CMP{1'b0}};
    end else begin
      lowpwr_q     <= idle_mode | sleep_mode; // RQ2
      cmp_pwr_en_q <= run_en; // RQ4 RQ5 RQ8
      dac_pwr_en_q <= run_en; // RQ8
    end
  end

  // ==========================================================
  // event consumers: adc trigger pulse and pwm limit level
  always @(posedge clk) begin
    if (srst) begin
      adc_trig_q  <= {NUM_CMP{1'b0}};
      pwm_limit_q <= {NUM_CMP{1'b0}};
    end else begin
      adc_trig_q  <= pls; // RQ6 RQ11
      pwm_limit_q <= lvl; // RQ11
    end
  end
endmodule

// [verilog/cmpl_defines.vh]
`ifndef CMPL_DEFINES_VH
`define CMPL_DEFINES_VH

// ==========================================================
// register byte offsets
`define CMPL_CTRL_BASE      8'h00
`define CMPL_DACV_BASE      8'h04
`define CMPL_CHAN_STRIDE    8'h08
`define CMPL_STAT_OFS       8'h40
`define CMPL_MASK_OFS       8'h44

// ==========================================================
// control register fields
`define CMPL_CTRL_EN_BIT    15
`define CMPL_CTRL_SIDL_BIT  13
`define CMPL_CTRL_POL_BIT   1
`define CMPL_CTRL_STAT_BIT  0
`define CMPL_CTRL_WMASK     16'ha002

// ==========================================================
// reset values
`define CMPL_CTRL_RST       16'h0000
`define CMPL_DAC_RST        10'h000

// ==========================================================
// widths and timing, in instruction cycles
`define CMPL_DAC_BITS       10
`define CMPL_FILT_CYCLES    2
`define CMPL_PULSE_CYCLES   1

`endif

// [verilog/cmpl_sync.v]
`timescale 1ns/100ps
// ==========================================================
// two-stage level synchroniser
module cmpl_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// [verilog/cmpl_chan.v]
`timescale 1ns/100ps
`include "cmpl_defines.vh"
// ==========================================================
// per-comparator polarity, glitch filter and event pulse
module cmpl_chan #(
  parameter FILT_CYCLES = `CMPL_FILT_CYCLES
) (
  input  wire clk,
  input  wire srst,
  input  wire cmp_sync,
  input  wire polarity,
  input  wire enable,
  input  wire bypass,
  output wire level,
  output wire pulse
);
  reg       filt_q;
  reg [3:0] cnt_q;
  reg       pulse_q;
  wire      cmp_pol;

  assign cmp_pol = cmp_sync ^ polarity; // RQ9

  always @(posedge clk) begin
    if (srst || !enable) begin
      filt_q  <= 1'b0;
      cnt_q   <= 4'h0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      if (bypass) begin
        // unfiltered path in low-power modes
        filt_q  <= cmp_pol; // RQ2
        cnt_q   <= 4'h0;
        pulse_q <= cmp_pol & ~filt_q; // RQ6 RQ12
      end else if (cmp_pol == filt_q) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == FILT_CYCLES[3:0] - 4'h1) begin
        // new level held long enough to pass
        filt_q  <= cmp_pol; // RQ1
        cnt_q   <= 4'h0;
        pulse_q <= cmp_pol; // RQ6 RQ12
      end else begin
        cnt_q <= cnt_q + 4'h1; // RQ1
      end
    end
  end

  assign level = filt_q;
  assign pulse = pulse_q;
endmodule

// [verification/cmpl_afe_model.sv]
`timescale 1ns/100ps
// ==========================================================
// comparator with reference dac on its inverting input
module cmpl_afe_model #(
  parameter NUM_CMP  = 4,
  parameter DAC_BITS = 10
) (
  input  wire [NUM_CMP*DAC_BITS-1:0] vin,
  input  wire [NUM_CMP*DAC_BITS-1:0] dac_code,
  input  wire [NUM_CMP-1:0]          pwr_en,
  output reg  [NUM_CMP-1:0]          cmp_out
);
  integer i;
  always @* begin
    for (i = 0; i < NUM_CMP; i = i + 1) begin
      cmp_out[i] = pwr_en[i] && (vin[i*DAC_BITS+:DAC_BITS] > dac_code[i*DAC_BITS+:DAC_BITS]);
    end
  end
endmodule

// [verification/cmpl_chk_asserts.sv]
`timescale 1ns/100ps
module cmpl_chk #(
  parameter NUM_CMP = 4
) (
  input wire               clk,
  input wire               srst,
  input wire               psel,
  input wire               penable,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               pslverr,
  input wire               idle_mode,
  input wire               sleep_mode,
  input wire [NUM_CMP-1:0] cmp_pwr_en_q,
  input wire [NUM_CMP-1:0] dac_pwr_en_q,
  input wire [NUM_CMP-1:0] adc_trig_q,
  input wire [NUM_CMP-1:0] wake_async
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready_time;
    s_req |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_trig_pulse;
    adc_trig_q != 0 |=> (adc_trig_q & $past(adc_trig_q)) == 0;
  endproperty
  property p_pwr_pair;
    dac_pwr_en_q == cmp_pwr_en_q;
  endproperty
  property p_wake_mode;
    !(idle_mode || sleep_mode) && !$past(idle_mode || sleep_mode) |-> wake_async == 0;
  endproperty
  property p_wake_pwr;
    (wake_async & ~cmp_pwr_en_q) == 0;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("pready late");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too wide");
  a_pwr_pair: assert property (p_pwr_pair) else $error("dac and comparator power differ");
  a_wake_mode: assert property (p_wake_mode) else $error("wake while running");
  a_wake_pwr: assert property (p_wake_pwr) else $error("wake from stopped comparator");
endmodule
bind cmpl_top cmpl_chk #(.NUM_CMP(NUM_CMP)) u_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
  .cmp_pwr_en_q(cmp_pwr_en_q), .dac_pwr_en_q(dac_pwr_en_q),
  .adc_trig_q(adc_trig_q), .wake_async(wake_async));

// [verification/cmpl_tb.sv]
`timescale 1ns/100ps
module tb;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, irq_q, idle_mode = 0, sleep_mode = 0;
  logic [3:0]  cmp_raw, dac_pwr_en_q, cmp_pwr_en_q, adc_trig_q, pwm_limit_q, wake_async;
  logic [39:0] dac_code_q, vin = 0;
  int          fails = 0, compares = 0, n;
  always #4 clk = ~clk;
  cmpl_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode), .cmp_raw(cmp_raw),
    .dac_code_q(dac_code_q), .dac_pwr_en_q(dac_pwr_en_q), .cmp_pwr_en_q(cmp_pwr_en_q),
    .adc_trig_q(adc_trig_q), .pwm_limit_q(pwm_limit_q), .wake_async(wake_async), .irq_q(irq_q));
  cmpl_afe_model afe (.vin(vin), .dac_code(dac_code_q), .pwr_en(cmp_pwr_en_q), .cmp_out(cmp_raw));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // counts channel 0 triggers, also used as a wait
  task pulses(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk);
      n += (adc_trig_q[0] === 1'b1);
    end
  endtask
  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #40000;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    xfer(0, 8'h00, 0);
    chk("ctrl0", rd, 32'h0);
    xfer(0, 8'h80, 0);
    chk("slverr", err, 1);
    xfer(1, 8'h04, 32'h155);
    xfer(1, 8'h00, 32'h8000);
    xfer(1, 8'h44, 1);
    pulses(4);
    chk("dac0", dac_code_q[9:0], 10'h155);
    chk("pwr", {dac_pwr_en_q[0], cmp_pwr_en_q[0]}, 2'b11);
    vin[9:0] <= 10'h200;
    @(posedge clk);
    vin[9:0] <= 0;
    pulses(20);
    chk("glitch", n, 0);
    vin[9:0] <= 10'h200;
    pulses(20);
    chk("pulses", n, 1);
    chk("irq", irq_q, 1);
    chk("pwm", pwm_limit_q[0], 1);
    xfer(0, 8'h40, 0);
    chk("stat", rd, 1);
    xfer(1, 8'h40, 1);
    pulses(4);
    chk("irq_clr", irq_q, 0);
    xfer(0, 8'h00, 0);
    chk("ctrl_lvl", rd, 32'h8001);
    xfer(1, 8'h00, 32'h8002);
    xfer(1, 8'h44, 0);
    pulses(10);
    chk("pol", pwm_limit_q[0], 0);
    sleep_mode <= 1;
    vin[9:0] <= 0;
    pulses(4);
    chk("wake", wake_async[0], 1);
    chk("irq_mask", irq_q, 0);
    sleep_mode <= 0;
    xfer(1, 8'h08, 32'h8000);
    xfer(1, 8'h00, 32'ha002);
    idle_mode <= 1;
    pulses(4);
    chk("idle_off", cmp_pwr_en_q, 4'h0);
    idle_mode <= 0;
    pulses(4);
    chk("idle_on", cmp_pwr_en_q, 4'h3);
    xfer(1, 8'h00, 0);
    pulses(4);
    chk("dis", cmp_pwr_en_q, 4'h2);
    print_verdict;
  end
endmodule
